/* File: rtl/prm_matrix.sv */
`timescale 1ns/1ps
`default_nettype none
`include "prm_cfg.svh"

module prm_matrix import prm_pkg::*; #(
  parameter logic [43:0] PIN_IMPL = 44'hfff_ffff_ffff
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic cfg_wr_en,
  input wire logic cfg_wr_out,
  input wire logic [5:0] cfg_wr_idx,
  input wire logic [5:0] cfg_wr_data,
  input wire logic osc_ctl_wr_en,
  input wire logic [7:0] osc_ctl_wr_data,
  input wire logic one_way_lock,
  output logic remap_write_lock,
  output logic cfg_mismatch_rst,
  input wire logic [43:0] pin_in,
  input wire logic [43:0] pin_analog_en,
  output logic [34:0] periph_in,
  input wire logic [63:0] periph_out,
  input wire logic [31:0] fixed_out_en,
  input wire logic [31:0] fixed_out,
  input wire logic [31:0] pin_direction_setting,
  input wire logic [31:0] gp_out,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe_n
);
  localparam int NIN = `PRM_NUM_IN;
  localparam int NIO = `PRM_NUM_IO;
  localparam logic [63:0] CODE_OK = `PRM_CODE_VALID_MASK;

  prm_seq_e seq_q;
  logic lock_q;
  logic in_wr;
  logic out_wr;
  logic in_mis;
  logic out_mis;
  logic [NIN*6-1:0] in_fields;
  logic [NIO*6-1:0] out_fields;
  logic [34:0] periph_in_d;
  logic [34:0] periph_in_q;
  logic [31:0] pin_out_d;
  logic [31:0] pin_out_q;
  logic [31:0] pin_oe_n_d;
  logic [31:0] pin_oe_n_q;
  logic mismatch_q;

  // Source pin for an input field: present, digital, in range
  function automatic logic in_route_ok(input logic [5:0] sel, input logic [43:0] analog);
    logic ok;
    ok = 1'b0;
    if (sel < 6'(`PRM_NUM_PINS)) begin
      ok = PIN_IMPL[sel] && !analog[sel];
    end
    return ok;
  endfunction

  // An output code names a function only if listed
  function automatic logic out_code_ok(input logic [5:0] code);
    return CODE_OK[code];
  endfunction

  // Unlock sequence: two key bytes, then one lock write.
  // Any other byte drops back, except a repeated first key, which keeps it waiting for the second.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      seq_q <= PRM_SEQ_IDLE;
    end else if (osc_ctl_wr_en) begin
      case (seq_q)
        PRM_SEQ_IDLE: begin
          seq_q <= (osc_ctl_wr_data == `PRM_UNLOCK_A) ? PRM_SEQ_GOT_A : PRM_SEQ_IDLE;
        end
        PRM_SEQ_GOT_A: begin
          if (osc_ctl_wr_data == `PRM_UNLOCK_B) begin
            seq_q <= PRM_SEQ_ARMED;
          end else if (osc_ctl_wr_data == `PRM_UNLOCK_A) begin
            seq_q <= PRM_SEQ_GOT_A;
          end else begin
            seq_q <= PRM_SEQ_IDLE;
          end
        end
        PRM_SEQ_ARMED: begin
          seq_q <= PRM_SEQ_IDLE;
        end
        default: begin
          seq_q <= PRM_SEQ_IDLE;
        end
      endcase
    end
  end

  // Lock bit: resets open; one-way strap forbids clearing once set
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lock_q <= 1'b0;
    end else if (osc_ctl_wr_en && seq_q == PRM_SEQ_ARMED) begin
      if (osc_ctl_wr_data[`PRM_LOCK_BIT] || !(one_way_lock && lock_q)) begin
        lock_q <= osc_ctl_wr_data[`PRM_LOCK_BIT];
      end
    end
  end

  // Writes while locked appear to work but change nothing
  assign in_wr = cfg_wr_en && !cfg_wr_out && !lock_q;
  // Output fields of absent pins and of input-only pins do not exist
  assign out_wr = cfg_wr_en && cfg_wr_out && !lock_q && cfg_wr_idx < 6'(NIO)
    && PIN_IMPL[cfg_wr_idx[4:0]];

  // One field per peripheral input, reset to the tied-low code
  prm_sel_bank #(
    .N(NIN),
    .RST_VAL(`PRM_IN_RST)
  ) u_in_bank (
    .clock(clock),
    .sys_rst(sys_rst),
    .wr_en(in_wr),
    .wr_idx(cfg_wr_idx),
    .wr_data(cfg_wr_data),
    .fields(in_fields),
    .mismatch(in_mis)
  );

  // One field per bidirectional pin, reset to null
  prm_sel_bank #(
    .N(NIO),
    .RST_VAL(`PRM_OUT_RST)
  ) u_out_bank (
    .clock(clock),
    .sys_rst(sys_rst),
    .wr_en(out_wr),
    .wr_idx(cfg_wr_idx),
    .wr_data(cfg_wr_data),
    .fields(out_fields),
    .mismatch(out_mis)
  );

  // Fault request registered, high for as long as either bank reports a mismatch
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mismatch_q <= 1'b0;
    end else begin
      mismatch_q <= in_mis || out_mis;
    end
  end

  // Input routing; unmapped inputs read low
  always_comb begin
    logic [5:0] sel;
    sel = 6'h00;
    periph_in_d = '0;
    for (int i = 0; i < NIN; i++) begin
      sel = in_fields[i*6 +: 6];
      periph_in_d[i] = in_route_ok(sel, pin_analog_en) ? pin_in[sel] : 1'b0;
    end
  end

  // Pin driver ownership: fixed, then remapped, then port direction.
  // Input routing never appears here, so it cannot seize a driver.
  always_comb begin
    logic [5:0] code;
    code = 6'h00;
    pin_out_d = '0;
    pin_oe_n_d = '1;
    for (int p = 0; p < NIO; p++) begin
      code = out_fields[p*6 +: 6];
      if (fixed_out_en[p]) begin
        pin_out_d[p] = fixed_out[p];
        pin_oe_n_d[p] = 1'b0;
      end else if (out_code_ok(code)) begin
        pin_out_d[p] = periph_out[code];
        pin_oe_n_d[p] = 1'b0;
      end else if (!pin_direction_setting[p]) begin
        pin_out_d[p] = gp_out[p];
        pin_oe_n_d[p] = 1'b0;
      end
    end
  end

  // Registered routes: a field change lands cleanly on the next edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      periph_in_q <= '0;
    end else begin
      periph_in_q <= periph_in_d;
    end
  end

  // Pin drivers released during reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_out_q <= '0;
      pin_oe_n_q <= '1;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_n_q <= pin_oe_n_d;
    end
  end

  // Only pins 0-31 have driver outputs; 32-43 are sampled only
  assign pin_out = pin_out_q;
  assign pin_oe_n = pin_oe_n_q;
  assign periph_in = periph_in_q;
  assign remap_write_lock = lock_q;
  assign cfg_mismatch_rst = mismatch_q;
  // Two-wire serial, change notification, calendar, parallel port,
  // display, analog and external_irq_zero never pass through here
  // Pin count is fixed at 44, PIN_IMPL trims a variant

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // Locked fields never move
  chk_lock_holds: assert property (lock_q |=> $stable(in_fields) && $stable(out_fields))
    else $error("select field changed while locked");

  // Lock only moves on the third write of a sequence, to that write's bit
  chk_lock_seq: assert property ($changed(lock_q) |-> $past(seq_q) == PRM_SEQ_ARMED
    && $past(osc_ctl_wr_en) && lock_q == $past(osc_ctl_wr_data[`PRM_LOCK_BIT]))
    else $error("lock changed without unlock sequence");

  // No oscillator control write, no lock movement
  chk_lock_idle: assert property (!osc_ctl_wr_en |=> $stable(lock_q))
    else $error("lock moved without a write");

  // Setting the lock after the keys is always allowed
  chk_lock_sets: assert property (osc_ctl_wr_en && seq_q == PRM_SEQ_ARMED
    && osc_ctl_wr_data[`PRM_LOCK_BIT] |=> lock_q)
    else $error("lock not set after unlock sequence");

  // A stray byte while idle never starts the sequence
  chk_seq_drop: assert property (osc_ctl_wr_en && seq_q == PRM_SEQ_IDLE
    && osc_ctl_wr_data != `PRM_UNLOCK_A |=> seq_q == PRM_SEQ_IDLE)
    else $error("unlock sequence started without first key");

  // One-way strap keeps the lock set
  chk_one_way: assert property (one_way_lock && lock_q |=> lock_q)
    else $error("lock cleared under one-way strap");

  // Fields come out of reset at their documented values
  chk_reset_vals: assert property ($past(sys_rst) |-> in_fields == {NIN{`PRM_IN_RST}}
    && out_fields == {NIO{`PRM_OUT_RST}})
    else $error("select fields not at reset values");

  // Input-only pins own no output field, so such writes are lost
  chk_in_only_pins: assert property (cfg_wr_en && cfg_wr_out && cfg_wr_idx >= 6'(NIO)
    |=> $stable(out_fields))
    else $error("write to an input-only pin moved a field");

  // Input indices past the last peripheral input are dropped
  chk_in_idx_drop: assert property (cfg_wr_en && !cfg_wr_out && cfg_wr_idx >= 6'(NIN)
    |=> $stable(in_fields))
    else $error("write past the last input field moved a field");

  // Mismatch must stay quiet when nothing disturbs the cells
  chk_no_false_mis: assert property (!in_mis && !out_mis |=> !cfg_mismatch_rst)
    else $error("spurious mismatch reset");

  genvar gp;
  for (gp = 0; gp < NIO; gp++) begin : g_pin_chk
    // Fixed output owns the pin and drives its value
    chk_fixed_prio: assert property (fixed_out_en[gp] |=> !pin_oe_n[gp]
      && pin_out[gp] == $past(fixed_out[gp]))
      else $error("fixed output lost pin ownership");
    // A listed code drives the pin from its peripheral
    chk_remap_drive: assert property (!fixed_out_en[gp] && CODE_OK[out_fields[gp*6 +: 6]]
      |=> !pin_oe_n[gp] && pin_out[gp] == $past(periph_out[out_fields[gp*6 +: 6]]))
      else $error("remapped output not driven");
    // Null or unlisted code falls back to the port direction
    chk_null_code: assert property (!fixed_out_en[gp] && !CODE_OK[out_fields[gp*6 +: 6]]
      |=> pin_oe_n[gp] == $past(pin_direction_setting[gp]))
      else $error("null code drove the pin");
    // Port output shows through where no remap owns the pin
    chk_port_drive: assert property (!fixed_out_en[gp] && !CODE_OK[out_fields[gp*6 +: 6]]
      && !pin_direction_setting[gp] |=> pin_out[gp] == $past(gp_out[gp]))
      else $error("port output not driven");
    // Released pin holds its drive value low so nothing stale lingers
    chk_released_low: assert property (!fixed_out_en[gp] && !CODE_OK[out_fields[gp*6 +: 6]]
      && pin_direction_setting[gp] |=> !pin_out[gp])
      else $error("released pin shows a value");
    // An accepted field write lands on the next edge
    chk_out_write: assert property (out_wr && cfg_wr_idx == 6'(gp)
      |=> out_fields[gp*6 +: 6] == $past(cfg_wr_data))
      else $error("output field write lost");
  end

  genvar gi;
  for (gi = 0; gi < NIN; gi++) begin : g_in_chk
    // Routed pin value reaches the peripheral one edge later
    chk_in_route: assert property (in_route_ok(in_fields[gi*6 +: 6], pin_analog_en)
      |=> periph_in[gi] == $past(pin_in[in_fields[gi*6 +: 6]]))
      else $error("routed input value wrong");
    // Out-of-range, absent or analog source reads low
    chk_in_dead: assert property (!in_route_ok(in_fields[gi*6 +: 6], pin_analog_en)
      |=> !periph_in[gi])
      else $error("unmapped input not low");
    // An accepted field write lands on the next edge
    chk_in_write: assert property (in_wr && cfg_wr_idx == 6'(gi)
      |=> in_fields[gi*6 +: 6] == $past(cfg_wr_data))
      else $error("input field write lost");
  end
endmodule // prm_matrix

`default_nettype wire

/* File: rtl/prm_cfg.svh */
// Operation
// - At most 44 remappable pins, variant dependent
// - Pins 0-31 bidirectional, 32-43 input only
// - Input-only pins never driven by outputs
// - Input field value n routes pin n
// - Each bidirectional pin owns output select field
// - Output code zero leaves pin unconnected
// - Comparator and output compare code assignments
// - Serial peripheral output code assignments
// - UART transmit and request-to-send codes
// - Input fields for all listed peripheral inputs
// - Remapped output overrides port functions
// - Fixed dedicated outputs override remapped outputs
// - Remapped inputs never take pin driver
// - Analog mode disables remapped input path
// - No default pin connection after reset
// - Valid input values limited to implemented pins
// - Listed fixed signals are never routed
// - Input and output routing fully independent
// - Unimplemented or above-43 input values unmapped
// - Reset: inputs all ones, outputs zero
// - Lock bit blocks writes; 46h/57h unlock sequence
// - Shadow copies flag unexpected select changes
`ifndef PRM_CFG_SVH
`define PRM_CFG_SVH

`define PRM_SEL_W 6
`define PRM_NUM_PINS 44
`define PRM_NUM_IO 32
`define PRM_NUM_IN 35
`define PRM_NUM_CODES 64
`define PRM_IN_RST 6'h3f
`define PRM_OUT_RST 6'h00
`define PRM_UNLOCK_A 8'h46
`define PRM_UNLOCK_B 8'h57
`define PRM_LOCK_BIT 6
`define PRM_CODE_NULL 6'h00
`define PRM_CODE_CMP_A 6'h01
`define PRM_CODE_CMP_B 6'h02
`define PRM_CODE_UART_A_TX 6'h03
`define PRM_CODE_SER_A_DATA 6'h07
`define PRM_CODE_SER_B_SEL 6'h0c
`define PRM_CODE_CMP_OC1 6'h12
`define PRM_CODE_CMP_OC7 6'h18
`define PRM_CODE_UART_C_TX 6'h1c
`define PRM_CODE_UART_D_RTS 6'h1f
`define PRM_CODE_CMP_C 6'h24
`define PRM_CODE_MOD_OUT 6'h25
// Codes 1-12, 18-24, 28-31, 36, 37 carry a function
`define PRM_CODE_VALID_MASK 64'h0000_0030_f1fc_1ffe

`endif

/* File: rtl/prm_pkg.sv */
package prm_pkg;
  // Peripheral input index, order of the input_route_select fields
  typedef enum logic [5:0] {
    PRM_IN_MOD_DATA, PRM_IN_MOD_CAR_A, PRM_IN_MOD_CAR_B,
    PRM_IN_IRQ1, PRM_IN_IRQ2, PRM_IN_IRQ3, PRM_IN_IRQ4,
    PRM_IN_CAP1, PRM_IN_CAP2, PRM_IN_CAP3, PRM_IN_CAP4, PRM_IN_CAP5, PRM_IN_CAP6, PRM_IN_CAP7,
    PRM_IN_FAULT_A, PRM_IN_FAULT_B,
    PRM_IN_SER_A_CLK, PRM_IN_SER_A_DATA, PRM_IN_SER_A_SEL,
    PRM_IN_SER_B_CLK, PRM_IN_SER_B_DATA, PRM_IN_SER_B_SEL,
    PRM_IN_TMR1_CLK, PRM_IN_TMR2_CLK, PRM_IN_TMR3_CLK, PRM_IN_TMR4_CLK, PRM_IN_TMR5_CLK,
    PRM_IN_UART_A_CTS, PRM_IN_UART_A_RX, PRM_IN_UART_B_CTS, PRM_IN_UART_B_RX,
    PRM_IN_UART_C_CTS, PRM_IN_UART_C_RX, PRM_IN_UART_D_CTS, PRM_IN_UART_D_RX
  } prm_in_e;

  // Unlock sequence progress for the remap write lock
  typedef enum logic [1:0] {
    PRM_SEQ_IDLE,
    PRM_SEQ_GOT_A,
    PRM_SEQ_ARMED
  } prm_seq_e;
endpackage

/* File: rtl/prm_sel_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "prm_cfg.svh"

module prm_sel_bank import prm_pkg::*; #(
  parameter int N = 2,
  parameter logic [5:0] RST_VAL = 6'h00
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [5:0] wr_idx,
  input wire logic [5:0] wr_data,
  output logic [N*6-1:0] fields,
  output logic mismatch
);
  logic [5:0] mem_q [N];
  logic [5:0] shadow_q [N];
  logic mismatch_q;

  // Live fields; writes beyond N are dropped
  always_ff @(posedge clock) begin
    for (int i = 0; i < N; i++) begin
      if (sys_rst) begin
        mem_q[i] <= RST_VAL;
      end else if (wr_en && wr_idx == 6'(i)) begin
        mem_q[i] <= wr_data;
      end
    end
  end

  // Shadow follows the same legal writes, so any other change is a fault
  always_ff @(posedge clock) begin
    for (int i = 0; i < N; i++) begin
      if (sys_rst) begin
        shadow_q[i] <= RST_VAL;
      end else if (wr_en && wr_idx == 6'(i)) begin
        shadow_q[i] <= wr_data;
      end
    end
  end

  // Continuous compare of live against shadow
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mismatch_q <= 1'b0;
    end else begin
      mismatch_q <= 1'b0;
      for (int i = 0; i < N; i++) begin
        if (mem_q[i] != shadow_q[i]) begin
          mismatch_q <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      fields[i*6 +: 6] = mem_q[i];
    end
  end
  assign mismatch = mismatch_q;
endmodule // prm_sel_bank

`default_nettype wire

/* File: test/prm_periph_model.sv */
`timescale 1ns/1ps
`default_nettype none

module prm_periph_model (
  input wire logic clock,
  output logic [63:0] periph_out,
  output logic [43:0] pin_in
);
  logic [31:0] x_q = 32'h1234_5678;

  // Fresh pattern every cycle so a stale route cannot pass
  always @(negedge clock) begin
    x_q <= x_q * 32'h0019_660d + 32'h3c6e_f35f;
  end

  // Peripherals run whether routed or not; no default pin exists
  assign periph_out = {x_q, ~{x_q[15:0], x_q[31:16]}};
  assign pin_in = {x_q[27:16], x_q ^ {x_q[7:0], x_q[31:8]}};
endmodule // prm_periph_model

`default_nettype wire

/* File: test/test_peripheral_pin_remap_matrix.sv */
`timescale 1ns/1ps
`default_nettype none

module test_peripheral_pin_remap_matrix;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic wr_en = 1'b0;
  logic wr_out = 1'b0;
  logic [5:0] wr_idx = 6'h00;
  logic [5:0] wr_data = 6'h00;
  logic osc_en = 1'b0;
  logic one_way = 1'b0;
  logic [7:0] osc_data = 8'h00;
  logic [43:0] ana = 44'h0;
  logic [31:0] fen = 32'h0;
  logic [31:0] fout = 32'h0;
  logic [31:0] dir = 32'hffff_ffff;
  logic [31:0] gp = 32'h0;
  logic lock;
  logic mism;
  logic [43:0] pin_in;
  logic [63:0] periph_out;
  logic [34:0] periph_in;
  logic [31:0] pin_out;
  logic [31:0] pin_oe_n;
  logic [5:0] ic [35];
  logic [5:0] oc [32];
  logic tb_lock = 1'b0;
  int mismatches = 0;
  int cmp_count = 0;

  // 40 MHz system clock
  always #12.5 clock = ~clock;

  prm_periph_model model (.clock(clock), .periph_out(periph_out), .pin_in(pin_in));

  prm_matrix uut (
    .clock(clock), .sys_rst(sys_rst), .cfg_wr_en(wr_en), .cfg_wr_out(wr_out), .cfg_wr_idx(wr_idx),
    .cfg_wr_data(wr_data), .osc_ctl_wr_en(osc_en), .osc_ctl_wr_data(osc_data), .one_way_lock(one_way),
    .remap_write_lock(lock), .cfg_mismatch_rst(mism), .pin_in(pin_in), .pin_analog_en(ana),
    .periph_in(periph_in), .periph_out(periph_out), .fixed_out_en(fen), .fixed_out(fout),
    .pin_direction_setting(dir), .gp_out(gp), .pin_out(pin_out), .pin_oe_n(pin_oe_n)
  );

  // Codes that carry a function; all others behave as null
  function automatic logic vld(input logic [5:0] c);
    return (c >= 6'h01 && c <= 6'h0c) || (c >= 6'h12 && c <= 6'h18) || (c >= 6'h1c && c <= 6'h1f) ||
      c == 6'h24 || c == 6'h25;
  endfunction

  task automatic chk_vec(input string n, input logic [34:0] e, input logic [34:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // Shadow tracks only writes the lock lets through
  task automatic wr(input logic o, input logic [5:0] i, input logic [5:0] d);
    @(negedge clock);
    wr_en = 1'b1;
    wr_out = o;
    wr_idx = i;
    wr_data = d;
    if (!tb_lock && o && i < 6'h20) oc[i] = d;
    if (!tb_lock && !o && i < 6'h23) ic[i] = d;
    @(negedge clock);
    wr_en = 1'b0;
  endtask

  task automatic osc(input logic [7:0] d);
    @(negedge clock);
    osc_en = 1'b1;
    osc_data = d;
    @(negedge clock);
    osc_en = 1'b0;
  endtask

  task automatic chk_lock(input logic e);
    @(posedge clock);
    #1;
    chk_vec("remap_write_lock", {34'h0, e}, {34'h0, lock});
  endtask

  // Expectation from inputs seen just before the sampling edge
  task automatic check_all();
    logic [34:0] ei;
    logic [31:0] eo;
    logic [31:0] ee;
    @(negedge clock);
    #2;
    for (int i = 0; i < 35; i++) begin
      ei[i] = (ic[i] < 6'h2c && !ana[ic[i]]) ? pin_in[ic[i]] : 1'b0;
    end
    for (int p = 0; p < 32; p++) begin
      ee[p] = 1'b0;
      eo[p] = 1'b0;
      if (fen[p]) eo[p] = fout[p];
      else if (vld(oc[p])) eo[p] = periph_out[oc[p]];
      else if (!dir[p]) eo[p] = gp[p];
      else ee[p] = 1'b1;
    end
    @(posedge clock);
    #1;
    chk_vec("periph_in", ei, periph_in);
    chk_vec("pin_out", {3'h0, eo}, {3'h0, pin_out});
    chk_vec("pin_oe_n", {3'h0, ee}, {3'h0, pin_oe_n});
    chk_vec("cfg_mismatch_rst", 35'h0, {34'h0, mism});
  endtask

  task automatic print_verdict();
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    foreach (ic[i]) ic[i] = 6'h3f;
    foreach (oc[i]) oc[i] = 6'h00;
    repeat (2) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    check_all();
    for (int c = 0; c < 64; c++) begin
      wr(1'b1, 6'h05, c[5:0]);
      check_all();
    end
    for (int i = 0; i < 35; i++) wr(1'b0, i[5:0], i[5:0] + 6'h08);
    check_all();
    // Writes past the last input field and to input-only pins go nowhere
    wr(1'b0, 6'h23, 6'h00);
    wr(1'b1, 6'h20, 6'h01);
    check_all();
    @(negedge clock);
    ana = 44'h0aa_aaaa_aaaa;
    check_all();
    wr(1'b0, 6'h00, 6'h2b);
    wr(1'b0, 6'h01, 6'h2c);
    wr(1'b0, 6'h02, 6'h3f);
    check_all();
    @(negedge clock);
    dir = 32'h0;
    gp = 32'h5555_aaaa;
    wr(1'b1, 6'h07, 6'h03);
    check_all();
    @(negedge clock);
    fen = 32'h0000_0081;
    fout = 32'h0000_0080;
    check_all();
    osc(8'h46);
    osc(8'h57);
    osc(8'h40);
    tb_lock = 1'b1;
    chk_lock(1'b1);
    wr(1'b1, 6'h05, 6'h01);
    check_all();
    osc(8'h46);
    osc(8'h12);
    osc(8'h57);
    osc(8'h00);
    chk_lock(1'b1);
    osc(8'h46);
    osc(8'h57);
    osc(8'h00);
    tb_lock = 1'b0;
    chk_lock(1'b0);
    wr(1'b1, 6'h05, 6'h01);
    check_all();
    @(negedge clock);
    one_way = 1'b1;
    osc(8'h46);
    osc(8'h57);
    osc(8'h40);
    osc(8'h46);
    osc(8'h57);
    osc(8'h00);
    chk_lock(1'b1);
    chk_vec("cfg_mismatch_rst", 35'h0, {34'h0, mism});
    print_verdict();
  end
endmodule // test_peripheral_pin_remap_matrix

`default_nettype wire
